// ==== moc_consts.vh ====
// Constants for the main oscillator control block
`ifndef MOC_CONSTS_VH
`define MOC_CONSTS_VH

// Register bus widths
`define MOC_ADDR_W 8
`define MOC_DATA_W 32

// Register byte offsets
`define MOC_OSC_CFG_OFS 8'h00
`define MOC_PWR_STAT_OFS 8'h04
`define MOC_IRQ_MASK_OFS 8'h08
`define MOC_FREQ_RES_OFS 8'h0C
`define MOC_EVT_STAT_OFS 8'h10

// Oscillator configuration fields
`define MOC_CFG_EN_BIT 0
`define MOC_CFG_BYP_BIT 1
`define MOC_CFG_CNT_LSB 8
`define MOC_CFG_CNT_MSB 15
`define MOC_CNT_W 8

// Power status fields
`define MOC_STAT_STABLE_BIT 0
`define MOC_STAT_BYP_BIT 1

// Event status and mask layout
`define MOC_EVT_W 2
`define MOC_EVT_STABLE_BIT 0
`define MOC_EVT_DONE_BIT 1

// Frequency result fields
`define MOC_FREQ_W 16
`define MOC_FREQ_DONE_BIT 16

// Timing figures
`define MOC_CORE_CLK_MHZ 250
`define MOC_SLOW_DIV 8
`define MOC_DIV_W 3
`define MOC_MEAS_PERIODS 16
`define MOC_PER_W 5

// Reset values
`define MOC_CNT_RST 8'h00
`define MOC_FREQ_RST 16'h0000
`define MOC_EVT_RST 2'h0
`define MOC_DATA_ZERO 32'h00000000

`endif

// ==== moc_slow_tick.v ====
// Slow clock edge detector and divide-by-eight tick generator
`timescale 1ns/100ps
`include "moc_consts.vh"

module moc_slow_tick (
	input wire core_clk,
	input wire nrst,
	input wire slowClk,
	output reg slowRise,
	output reg slowFall,
	output reg div8Tick
);

	reg slowPrev_ff; // Last sampled slow clock level
	reg [`MOC_DIV_W-1:0] divCnt_ff; // Slow period counter
	reg [`MOC_DIV_W-1:0] nxt_divCnt;
	reg nxt_divTick;

	// Edge and divider next values
	always @* begin
		nxt_divCnt = divCnt_ff;
		nxt_divTick = 1'b0;
		if (slowClk && !slowPrev_ff) begin
			// One slow period passes per rising edge
			nxt_divCnt = divCnt_ff + 3'h1;
			if (divCnt_ff == (`MOC_SLOW_DIV - 1)) begin
				nxt_divTick = 1'b1;
			end
		end
	end

	// Registered pulses, one core cycle each
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slowPrev_ff <= 1'b0;
			divCnt_ff <= 3'h0;
			slowRise <= 1'b0;
			slowFall <= 1'b0;
			div8Tick <= 1'b0;
		end else begin
			slowPrev_ff <= slowClk;
			divCnt_ff <= nxt_divCnt;
			slowRise <= slowClk & ~slowPrev_ff;
			slowFall <= ~slowClk & slowPrev_ff;
			div8Tick <= nxt_divTick;
		end
	end

endmodule // moc_slow_tick

// ==== moc_top.v ====
// Main oscillator control: enable, startup timing, bypass and frequency measurement
`timescale 1ns/100ps
`include "moc_consts.vh"

module moc_top (
	input wire core_clk,
	input wire nrst,
	input wire [`MOC_ADDR_W-1:0] regAddr,
	input wire [`MOC_DATA_W-1:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [`MOC_DATA_W-1:0] regRdata,
	input wire slowClk,
	input wire oscClkIn,
	input wire crystalInPin,
	output reg mainOscEnable,
	output reg oscBypassSelect,
	output reg mainClk,
	output reg mainClkValid,
	output reg irq
);

	// Timing notes
	// Free-running slow/8 divider, not restarted by a write
	// First tick anywhere in the first eight slow periods
	// Startup lasts count-1 to count whole ticks
	// Software adds one tick of margin
	// Zero count: stable two core cycles after the write
	// Window: slow rising edge to sixteenth falling edge
	// Main clock rising edges counted inside the window
	// Slow and oscillator levels taken as synchronous
	// Both must change far slower than core_clk

	// One-hot measurement states
	localparam [3:0] MEAS_IDLE = 4'h1;
	localparam [3:0] MEAS_ARM = 4'h2;
	localparam [3:0] MEAS_RUN = 4'h4;
	localparam [3:0] MEAS_DONE = 4'h8;

	// Address decode shared by reads and writes
	function hit;
		input [`MOC_ADDR_W-1:0] addr;
		input [`MOC_ADDR_W-1:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// Slow clock timing pulses
	wire slowRise; // Slow clock rising edge
	wire slowFall; // Slow clock falling edge
	wire div8Tick; // Slow clock divided by eight

	// Configuration registers
	reg oscEn_ff; // Main oscillator enable
	reg bypass_ff; // Bypass select
	reg [`MOC_CNT_W-1:0] startCnt_ff; // Startup count as written
	reg [`MOC_EVT_W-1:0] mask_ff; // Interrupt mask
	reg [`MOC_EVT_W-1:0] evt_ff; // Sticky event status

	// Oscillator startup state
	reg [`MOC_CNT_W-1:0] downCnt_ff; // Startup down-counter
	reg counting_ff; // Down-counter active
	reg stable_ff; // Main oscillator stable flag

	// Measurement state
	reg [3:0] measState_ff; // One-hot measurement state
	reg [`MOC_FREQ_W-1:0] freq_ff; // Main cycles counted
	reg [`MOC_PER_W-1:0] falls_ff; // Slow falling edges seen
	reg done_ff; // Measurement done flag
	reg mainPrev_ff; // Last sampled main clock level

	// Next values
	reg nxt_oscEn;
	reg nxt_bypass;
	reg [`MOC_CNT_W-1:0] nxt_startCnt;
	reg [`MOC_EVT_W-1:0] nxt_mask;
	reg [`MOC_EVT_W-1:0] nxt_evt;
	reg [`MOC_CNT_W-1:0] nxt_downCnt;
	reg nxt_counting;
	reg nxt_stable;
	reg [3:0] nxt_measState;
	reg [`MOC_FREQ_W-1:0] nxt_freq;
	reg [`MOC_PER_W-1:0] nxt_falls;
	reg nxt_done;
	reg [`MOC_DATA_W-1:0] nxt_rdata;
	reg nxt_mainClk;

	// Decoded strobes
	wire cfgWr; // Configuration write
	wire maskWr; // Mask write
	wire evtRd; // Event status read
	wire restart; // Enabling write
	wire cfgOff; // Enable cleared by write
	wire mainRise; // Main clock rising edge
	wire stableSet; // Stable flag rising this cycle

	assign cfgWr = regWr && hit(regAddr, `MOC_OSC_CFG_OFS);
	assign maskWr = regWr && hit(regAddr, `MOC_IRQ_MASK_OFS);
	assign evtRd = regRd && hit(regAddr, `MOC_EVT_STAT_OFS);
	// Any enabling write restarts startup, even when already enabled
	assign restart = cfgWr && regWdata[`MOC_CFG_EN_BIT];
	assign cfgOff = cfgWr && !regWdata[`MOC_CFG_EN_BIT];
	assign mainRise = oscClkIn && !mainPrev_ff;
	assign stableSet = nxt_stable && !stable_ff;

	// Slow clock edges and divided tick
	moc_slow_tick u_slowTick (
		.core_clk(core_clk),
		.nrst(nrst),
		.slowClk(slowClk),
		.slowRise(slowRise),
		.slowFall(slowFall),
		.div8Tick(div8Tick)
	);

	// Configuration register writes
	always @* begin
		nxt_oscEn = oscEn_ff;
		nxt_bypass = bypass_ff;
		nxt_startCnt = startCnt_ff;
		nxt_mask = mask_ff;
		if (cfgWr) begin
			// Enable, bypass and count in one word
			nxt_oscEn = regWdata[`MOC_CFG_EN_BIT];
			nxt_bypass = regWdata[`MOC_CFG_BYP_BIT];
			nxt_startCnt = regWdata[`MOC_CFG_CNT_MSB:`MOC_CFG_CNT_LSB];
		end
		if (maskWr) begin
			// Mask shares the event layout
			nxt_mask = regWdata[`MOC_EVT_W-1:0];
		end
	end

	// Startup down-counter and stable flag
	always @* begin
		nxt_downCnt = downCnt_ff;
		nxt_counting = counting_ff;
		nxt_stable = stable_ff;
		if (cfgOff) begin
			// Oscillator no longer reported stable
			nxt_stable = 1'b0;
			nxt_counting = 1'b0;
			nxt_downCnt = `MOC_CNT_RST;
		end else if (restart) begin
			// Fresh startup from the written count
			nxt_stable = 1'b0;
			nxt_counting = 1'b1;
			nxt_downCnt = regWdata[`MOC_CFG_CNT_MSB:`MOC_CFG_CNT_LSB];
		end else if (counting_ff) begin
			// Zero tested first, so a zero count needs no tick
			if (downCnt_ff == `MOC_CNT_RST) begin
				// Startup time elapsed
				nxt_stable = 1'b1;
				nxt_counting = 1'b0;
			end else if (div8Tick) begin
				// Decrement at slow clock over eight
				nxt_downCnt = downCnt_ff - 8'h01;
			end
		end
	end

	// Frequency measurement sequence
	always @* begin
		nxt_measState = measState_ff;
		nxt_freq = freq_ff;
		nxt_falls = falls_ff;
		nxt_done = done_ff;
		if (cfgOff || restart) begin
			// Old result no longer valid
			nxt_measState = MEAS_IDLE;
			nxt_freq = `MOC_FREQ_RST;
			nxt_falls = 5'h00;
			nxt_done = 1'b0;
		end else begin
			case (measState_ff)
				MEAS_IDLE: begin
					// Wait for the stable flag
					if (stable_ff) begin
						nxt_measState = MEAS_ARM;
					end
				end
				MEAS_ARM: begin
					// Start on the next slow rising edge
					if (slowRise) begin
						nxt_measState = MEAS_RUN;
						nxt_falls = 5'h00;
						nxt_freq = `MOC_FREQ_RST;
					end
				end
				MEAS_RUN: begin
					// Count main cycles until the window closes
					if (mainRise) begin
						nxt_freq = freq_ff + 16'h0001;
					end
					if (slowFall) begin
						nxt_falls = falls_ff + 5'h01;
						if (falls_ff == (`MOC_MEAS_PERIODS - 1)) begin
							// Sixteenth falling edge ends the window
							nxt_measState = MEAS_DONE;
							nxt_done = 1'b1;
						end
					end
				end
				MEAS_DONE: begin
					// Result held until disable or restart
					nxt_measState = MEAS_DONE;
				end
				default: begin
					// Recover from an illegal code
					nxt_measState = MEAS_IDLE;
				end
			endcase
		end
	end

	// Sticky events; a new event beats the read clear
	always @* begin
		nxt_evt = evt_ff;
		if (evtRd) begin
			nxt_evt = `MOC_EVT_RST;
		end
		if (stableSet) begin
			nxt_evt[`MOC_EVT_STABLE_BIT] = 1'b1;
		end
		// Done event on the rising edge of the done flag
		if (nxt_done && !done_ff) begin
			nxt_evt[`MOC_EVT_DONE_BIT] = 1'b1;
		end
	end

	// Read data mux, zero for unmapped offsets
	always @* begin
		nxt_rdata = `MOC_DATA_ZERO;
		// Reads change nothing but the event clear
		if (regRd) begin
			if (hit(regAddr, `MOC_OSC_CFG_OFS)) begin
				nxt_rdata[`MOC_CFG_EN_BIT] = oscEn_ff;
				nxt_rdata[`MOC_CFG_BYP_BIT] = bypass_ff;
				nxt_rdata[`MOC_CFG_CNT_MSB:`MOC_CFG_CNT_LSB] = startCnt_ff;
			end else if (hit(regAddr, `MOC_PWR_STAT_OFS)) begin
				nxt_rdata[`MOC_STAT_STABLE_BIT] = stable_ff;
				nxt_rdata[`MOC_STAT_BYP_BIT] = bypass_ff;
			end else if (hit(regAddr, `MOC_IRQ_MASK_OFS)) begin
				nxt_rdata[`MOC_EVT_W-1:0] = mask_ff;
			end else if (hit(regAddr, `MOC_FREQ_RES_OFS)) begin
				nxt_rdata[`MOC_FREQ_W-1:0] = freq_ff;
				nxt_rdata[`MOC_FREQ_DONE_BIT] = done_ff;
			end else if (hit(regAddr, `MOC_EVT_STAT_OFS)) begin
				nxt_rdata[`MOC_EVT_W-1:0] = evt_ff;
			end
		end
	end

	// Main clock source: external input in bypass with the oscillator off, else stable oscillator
	// One core cycle of lag; edges only as fine as core_clk
	always @* begin
		if (bypass_ff && !oscEn_ff) begin
			nxt_mainClk = crystalInPin;
		end else if (stable_ff) begin
			nxt_mainClk = oscClkIn;
		end else begin
			nxt_mainClk = 1'b0;
		end
	end

	// Control and status registers
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// Oscillator off, slow clock in use
			oscEn_ff <= 1'b0;
			bypass_ff <= 1'b0;
			startCnt_ff <= `MOC_CNT_RST;
			mask_ff <= `MOC_EVT_RST;
			evt_ff <= `MOC_EVT_RST;
			downCnt_ff <= `MOC_CNT_RST;
			counting_ff <= 1'b0;
			stable_ff <= 1'b0;
		end else begin
			oscEn_ff <= nxt_oscEn;
			bypass_ff <= nxt_bypass;
			startCnt_ff <= nxt_startCnt;
			mask_ff <= nxt_mask;
			evt_ff <= nxt_evt;
			downCnt_ff <= nxt_downCnt;
			counting_ff <= nxt_counting;
			stable_ff <= nxt_stable;
		end
	end

	// Measurement registers
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			measState_ff <= MEAS_IDLE;
			freq_ff <= `MOC_FREQ_RST;
			falls_ff <= 5'h00;
			done_ff <= 1'b0;
			mainPrev_ff <= 1'b0;
		end else begin
			measState_ff <= nxt_measState;
			freq_ff <= nxt_freq;
			falls_ff <= nxt_falls;
			done_ff <= nxt_done;
			// Main clock level kept for edge detection
			mainPrev_ff <= oscClkIn;
		end
	end

	// Registered outputs
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= `MOC_DATA_ZERO;
			mainOscEnable <= 1'b0;
			oscBypassSelect <= 1'b0;
			mainClk <= 1'b0;
			mainClkValid <= 1'b0;
			irq <= 1'b0;
		end else begin
			regRdata <= nxt_rdata;
			mainOscEnable <= nxt_oscEn;
			oscBypassSelect <= nxt_bypass;
			mainClk <= nxt_mainClk;
			// Valid from stable, or bypass with the oscillator off
			mainClkValid <= nxt_stable | (nxt_bypass & ~nxt_oscEn);
			// Level interrupt from next events and mask
			irq <= |(nxt_evt & nxt_mask);
		end
	end

endmodule // moc_top

// ==== moc_top_checker.sv ====
// Port-level assertions for the oscillator control block
`timescale 1ns/100ps

module moc_chk (
	input wire core_clk,
	input wire nrst,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdata,
	input wire slowClk,
	input wire oscClkIn,
	input wire crystalInPin,
	input wire mainOscEnable,
	input wire oscBypassSelect,
	input wire mainClk,
	input wire mainClkValid,
	input wire irq
);
	reg maskStb_ff; // Copy of the stable event mask bit
	wire cfgWr = regWr && regAddr == 8'h00; // Config register write

	// Track the mask bit from bus writes
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			maskStb_ff <= 1'b0;
		else if (regWr && regAddr == 8'h08)
			maskStb_ff <= regWdata[0];
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	AST_RST: assert property ($rose(nrst) |-> !mainOscEnable && !mainClkValid && !irq)
		else $error("outputs not idle after reset");
	AST_DIS: assert property (cfgWr && regWdata[1:0] == 2'h0 |=> !mainOscEnable && !mainClkValid)
		else $error("disable left the clock valid");
	AST_EN: assert property (cfgWr && regWdata[0] |=> mainOscEnable && !mainClkValid)
		else $error("enable did not clear stable");
	AST_CNT0: assert property (cfgWr && regWdata[0] && regWdata[15:8] == 8'h00 ##1 !cfgWr |=> mainClkValid)
		else $error("zero count did not give stable");
	AST_IRQ: assert property ($rose(mainClkValid) && mainOscEnable && maskStb_ff |-> irq)
		else $error("unmasked stable gave no interrupt");
	AST_BYP: assert property (cfgWr && regWdata[1:0] == 2'h2 |=> oscBypassSelect ##[0:1] mainClkValid)
		else $error("bypass not selected");
	AST_XCLK: assert property (oscBypassSelect && !mainOscEnable
		&& $past(oscBypassSelect) && !$past(mainOscEnable) |-> mainClk == $past(crystalInPin))
		else $error("bypass clock not passed on");
	AST_OCLK: assert property (mainOscEnable && mainClkValid
		&& $past(mainOscEnable) && $past(mainClkValid) |-> mainClk == $past(oscClkIn))
		else $error("oscillator clock not passed on");
	AST_IDLE: assert property (!mainClkValid && !$past(mainClkValid) |-> !mainClk)
		else $error("main clock runs while not valid");

	COV_STB: cover property ($rose(mainClkValid) && mainOscEnable);
	COV_IRQ: cover property ($rose(irq));
	COV_BYP: cover property (oscBypassSelect && mainClkValid);
endmodule // moc_chk

bind moc_top moc_chk i_chk (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .slowClk(slowClk), .oscClkIn(oscClkIn),
	.crystalInPin(crystalInPin), .mainOscEnable(mainOscEnable), .oscBypassSelect(oscBypassSelect),
	.mainClk(mainClk), .mainClkValid(mainClkValid), .irq(irq));

// ==== moc_osc_model.sv ====
// Behavioural oscillator core, slow crystal and external clock source
`timescale 1ns/100ps

module moc_osc_model (
	input wire mainOscEnable,
	output reg oscClkIn,
	output reg slowClk,
	output reg crystalInPin
);
	reg oscOn; // Oscillator has settled

	// Slow clock never stops, 160 ns period
	initial begin
		slowClk = 1'b0;
		#3.3;
		forever #80 slowClk = ~slowClk;
	end

	// External clock for bypass mode, 20 ns period, edges kept off core edges
	initial begin
		crystalInPin = 1'b0;
		#1;
		forever #10 crystalInPin = ~crystalInPin;
	end

	// Settling delay after enable, instant stop on disable
	always @(mainOscEnable) begin
		if (mainOscEnable === 1'b1)
			oscOn <= #200 1'b1;
		else
			oscOn = 1'b0;
	end

	// Oscillator output, 16 ns period while running
	initial begin
		oscClkIn = 1'b0;
		#1;
		forever #8 oscClkIn = (oscOn === 1'b1) ? ~oscClkIn : 1'b0;
	end
endmodule // moc_osc_model

// ==== moc_top_tb.sv ====
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps

module moc_top_tb;
	reg core_clk = 1'b0; // 250 MHz core clock
	reg nrst = 1'b0; // Active-low reset
	reg [7:0] regAddr = 8'h00;
	reg [31:0] regWdata = 32'h0;
	reg regWr = 1'b0;
	reg regRd = 1'b0;
	reg rdPend = 1'b0; // Read answer due this cycle
	reg [31:0] lastRd = 32'h0; // Last word read
	reg [31:0] expQ[$]; // Expected words, masked
	reg [31:0] careQ[$]; // Compared bits per read
	wire [31:0] regRdata;
	wire slowClk, oscClkIn, crystalInPin, mainOscEnable, oscBypassSelect, mainClk, mainClkValid, irq;
	integer bad_count = 0;
	integer samples_checked = 0;
	integer n;
	integer k;

	always #2 core_clk = ~core_clk;

	moc_top i_dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .slowClk(slowClk), .oscClkIn(oscClkIn), .crystalInPin(crystalInPin),
		.mainOscEnable(mainOscEnable), .oscBypassSelect(oscBypassSelect), .mainClk(mainClk),
		.mainClkValid(mainClkValid), .irq(irq));
	moc_osc_model i_osc (.mainOscEnable(mainOscEnable), .oscClkIn(oscClkIn), .slowClk(slowClk),
		.crystalInPin(crystalInPin));

	// Compare and count
	task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	// Wait whole core cycles
	task cyc(input integer c);
		repeat (c) @(posedge core_clk);
	endtask

	// One-cycle register write
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
			@(posedge core_clk);
			regWr <= 1'b0;
		end
	endtask

	// One-cycle register read, expectation queued
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		begin
			@(posedge core_clk);
			regAddr <= a;
			regRd <= 1'b1;
			expQ.push_back(e & m);
			careQ.push_back(m);
			@(posedge core_clk);
			regRd <= 1'b0;
		end
	endtask

	// Verdict and end of run
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	// Read answers against the oldest note
	always @(posedge core_clk) begin
		rdPend <= regRd;
		if (rdPend) begin
			lastRd = regRdata;
			check(regRdata & careQ.pop_front(), expQ.pop_front(), "rdata");
		end
	end

	// Watchdog against a hang
	initial begin
		#100000;
		bad_count = bad_count + 1;
		finish_test;
	end

	// Main sequence
	initial begin
		n = $urandom(33530);
		cyc(2);
		nrst <= 1'b1;
		#1;
		check(mainOscEnable, 1'b0, "enable");
		check(mainClkValid, 1'b0, "valid");
		rd(8'h00, 32'h0, 32'hFFFFFFFF);
		n = $urandom % 256;
		wr(8'h00, n << 8);
		rd(8'h00, n << 8, 32'h0000FF03);
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h0, 32'hFFFFFFFF);
		// Zero count: stable at once, interrupt, read-clear
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h1);
		cyc(3);
		#1;
		check(irq, 1'b1, "irq");
		rd(8'h04, 32'h1, 32'h1);
		rd(8'h10, 32'h1, 32'h1);
		rd(8'h10, 32'h0, 32'h1);
		cyc(2);
		#1;
		check(irq, 1'b0, "irq");
		// Restart with a random count covering the crystal settling
		wr(8'h08, 32'h2);
		k = 2 + $urandom % 2;
		wr(8'h00, (k << 8) | 32'h1);
		rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		// One slow rise short of k-1 ticks, so the counter is not yet zero
		repeat ((k - 1) * 8 - 1) @(posedge slowClk);
		#1;
		check(mainClkValid, 1'b0, "valid");
		n = 0;
		// At most two ticks left, sixteen slow periods
		while (mainClkValid !== 1'b1 && n < 700) begin
			@(posedge core_clk);
			#1;
			n = n + 1;
		end
		check(mainClkValid, 1'b1, "valid");
		repeat (18) @(posedge slowClk);
		cyc(4);
		#1;
		check(irq, 1'b1, "irq");
		rd(8'h0C, 32'h00010000, 32'h00010000);
		cyc(2);
		check(lastRd[15:0] >= 16'h0099 && lastRd[15:0] <= 16'h00A1, 1'b1, "count");
		// Disable clears stable and the result
		wr(8'h00, 32'h0);
		cyc(1);
		#1;
		check(mainClkValid, 1'b0, "valid");
		rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		// External clock through bypass
		wr(8'h00, 32'h2);
		cyc(3);
		#1;
		check(mainClkValid, 1'b1, "valid");
		rd(8'h04, 32'h2, 32'h3);
		cyc(20);
		// Second reset in mid-run
		nrst <= 1'b0;
		cyc(2);
		#1;
		check(oscBypassSelect, 1'b0, "bypass");
		nrst <= 1'b1;
		cyc(2);
		finish_test;
	end
endmodule // moc_top_tb
